/* File: hdl/audio_in_capture.sv */
// Audio input capture: register slave, clock generation and serial receiver.
`timescale 1ns/1ps
`default_nettype none
module audio_in_capture
  import audio_in_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic oversample_clk_out,
  input wire logic serial_bit_clk_in,
  output logic serial_bit_clk_out,
  output logic serial_bit_clk_oe,
  input wire logic word_select_in,
  output logic word_select_out,
  output logic word_select_oe,
  input wire logic serial_data_in,
  output logic sample_valid,
  output var sample_t sample_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] freq_q;
  logic [31:0] clkctl_q;
  logic [31:0] frame_q;
  logic [31:0] pos_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic osc;
  logic gen_sck;
  logic gen_ws;
  rx_cfg_t cfg;
  logic overrun_q;

  assign addr_ok = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Configuration fields picked out of the software registers.
  always_comb begin
    cfg.master = clkctl_q[CLK_MASTER_BIT];
    cfg.edge_sel = clkctl_q[CLK_EDGE_BIT];
    cfg.frame_len_divide = clkctl_q[CLK_FRAME_LEN_DIVIDE_LSB +: 9];
    cfg.polarity = frame_q[FRM_POL_BIT];
    cfg.bit_order = frame_q[FRM_ORDER_BIT];
    cfg.mono = frame_q[FRM_MONO_BIT];
    cfg.sample_accept_mode = frame_q[FRM_MODE_LSB +: 2];
    cfg.start_stop_index = frame_q[FRM_START_STOP_INDEX_LSB +: 4];
    cfg.valid_bit_pos = frame_q[FRM_VALID_LSB +: 9];
    cfg.left_first_pos = pos_q[POS_LEFT_LSB +: 9];
    cfg.right_first_pos = pos_q[POS_RIGHT_LSB +: 9];
  end

  // Write address is latched in the address phase, data lands next cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Register storage; all fields come up as the reset defaults.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_q <= FREQ_RST;
      clkctl_q <= CLKCTL_RST;
      frame_q <= FRAME_RST;
      pos_q <= POS_RST;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        OFF_FREQ: freq_q <= hwdata;
        OFF_CLKCTL: clkctl_q <= hwdata & 32'h01FF_FF03;
        OFF_FRAME: frame_q <= hwdata & 32'h01FF_0F37;
        OFF_POS: pos_q <= hwdata & 32'h01FF_01FF;
        default: freq_q <= freq_q;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero with an OKAY answer.
  always_comb begin
    case (haddr[7:0])
      OFF_FREQ: rd_mux = freq_q;
      OFF_CLKCTL: rd_mux = clkctl_q;
      OFF_FRAME: rd_mux = frame_q;
      OFF_POS: rd_mux = pos_q;
      OFF_SAMPLE: rd_mux = sample_out;
      OFF_STATUS: rd_mux = {30'h0, overrun_q, sample_valid};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is registered so it stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  osclk_synth u_synth (
    .hclk(hclk),
    .hresetn(hresetn),
    .freq_word(freq_q),
    .osc_q(osc)
  );
  assign oversample_clk_out = osc;

  serial_master_gen u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc(osc),
    .bitclk_divide(clkctl_q[CLK_BITCLK_DIVIDE_LSB +: 8]),
    .frame_len_divide(cfg.frame_len_divide),
    .polarity(cfg.polarity),
    .edge_sel(cfg.edge_sel),
    .sck_q(gen_sck),
    .ws_q(gen_ws)
  );

  // Pin direction follows the master select.
  assign serial_bit_clk_oe = cfg.master;
  assign word_select_oe = cfg.master;
  assign serial_bit_clk_out = gen_sck;
  assign word_select_out = gen_ws;

  ////////////////////////////////////////////////////////////////////////////
  // The pin level is used even as master, so both modes see one path.
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic ws_s1_q, ws_s2_q, ws_s3_q;
  logic sd_s1_q, sd_s2_q, sd_s3_q;
  logic samp_edge;
  logic ws_prev_q;
  logic frame_start;
  logic [8:0] pos_cnt_q;
  logic in_frame_q;
  logic [4:0] lcnt_q, rcnt_q;
  logic [15:0] lsh_q, rsh_q;
  logic valid_ok_q, valid_seen_q;
  logic [4:0] nbits;
  logic frame_done_q;

  // Two-stage synchroniser, third stage for edge finding.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      // Word select idles high, so resetting to that level avoids a false start edge.
      {ws_s1_q, ws_s2_q, ws_s3_q} <= 3'h7;
      {sd_s1_q, sd_s2_q, sd_s3_q} <= 3'h0;
    end else begin
      sck_s1_q <= serial_bit_clk_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      ws_s1_q <= word_select_in;
      ws_s2_q <= ws_s1_q;
      ws_s3_q <= ws_s2_q;
      sd_s1_q <= serial_data_in;
      sd_s2_q <= sd_s1_q;
      sd_s3_q <= sd_s2_q;
    end
  end

  // Sampling edge: rising when edge select is 0, falling when 1.
  assign samp_edge = cfg.edge_sel ? (sck_s3_q & ~sck_s2_q) : (~sck_s3_q & sck_s2_q);
  assign frame_start = (ws_s3_q != ws_prev_q) && (ws_s3_q == cfg.polarity);
  assign nbits = 5'h10 - {1'b0, cfg.start_stop_index};

  // Frame position counter; the edge after the start edge is position 0.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ws_prev_q <= 1'b1;
      pos_cnt_q <= 9'h000;
      in_frame_q <= 1'b0;
    end else if (samp_edge) begin
      ws_prev_q <= ws_s3_q;
      if (frame_start) begin
        pos_cnt_q <= 9'h1FF;
        in_frame_q <= 1'b1;
      end else if (pos_cnt_q != 9'h1FE) begin
        pos_cnt_q <= pos_cnt_q + 9'h001;
      end
    end
  end

  // Channel shift registers: capture nbits starting at each first position.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lcnt_q <= 5'h00;
      rcnt_q <= 5'h00;
      lsh_q <= WORD_ZERO;
      rsh_q <= WORD_ZERO;
      valid_ok_q <= 1'b0;
      valid_seen_q <= 1'b0;
    end else if (samp_edge & frame_start) begin
      lcnt_q <= 5'h00;
      rcnt_q <= 5'h00;
      lsh_q <= WORD_ZERO;
      rsh_q <= WORD_ZERO;
      valid_seen_q <= 1'b0;
    end else if (samp_edge & in_frame_q) begin
      if ((pos_cnt_q + 9'h001 == cfg.left_first_pos && lcnt_q == 5'h00) ||
          (lcnt_q != 5'h00 && lcnt_q < nbits)) begin
        lcnt_q <= lcnt_q + 5'h01;
        lsh_q <= cfg.bit_order ? {sd_s3_q, lsh_q[15:1]} : {lsh_q[14:0], sd_s3_q};
      end
      if ((pos_cnt_q + 9'h001 == cfg.right_first_pos && rcnt_q == 5'h00) ||
          (rcnt_q != 5'h00 && rcnt_q < nbits)) begin
        rcnt_q <= rcnt_q + 5'h01;
        rsh_q <= cfg.bit_order ? {sd_s3_q, rsh_q[15:1]} : {rsh_q[14:0], sd_s3_q};
      end
      if (pos_cnt_q + 9'h001 == cfg.valid_bit_pos) begin
        valid_seen_q <= 1'b1;
        valid_ok_q <= (sd_s3_q == cfg.sample_accept_mode[0]);
      end
    end
  end

  // Align to the parallel word: MSB-first shifts up, LSB-first is placed.
  function automatic logic [15:0] align(input logic [15:0] sh, input logic ord,
                                        input logic [3:0] ss);
    logic [15:0] r;
    r = WORD_ZERO;
    if (ord) begin
      r = sh;
    end else begin
      r = sh << ss;
    end
    return r;
  endfunction

  logic done_now;
  logic accept;
  assign done_now = in_frame_q && (lcnt_q == nbits) &&
                    (cfg.mono || rcnt_q == nbits) && !frame_done_q &&
                    (cfg.sample_accept_mode == MODE_EVERY || valid_seen_q);
  assign accept = (cfg.sample_accept_mode == MODE_EVERY) ||
                  ((cfg.sample_accept_mode == MODE_VALID0 ||
                    cfg.sample_accept_mode == MODE_VALID1) && valid_ok_q);

  // Hand over once per accepted frame when all channel bits are in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_done_q <= 1'b0;
      sample_valid <= 1'b0;
      sample_out <= '0;
      overrun_q <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (samp_edge & frame_start) begin
        frame_done_q <= 1'b0;
      end else if (done_now) begin
        frame_done_q <= 1'b1;
        if (accept) begin
          sample_valid <= 1'b1;
          sample_out.left <= align(lsh_q, cfg.bit_order, cfg.start_stop_index);
          sample_out.right <= cfg.mono ? WORD_ZERO :
                              align(rsh_q, cfg.bit_order, cfg.start_stop_index);
          overrun_q <= overrun_q | sample_valid;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  reset_slave_a: assert property (@(posedge hclk) $rose(hresetn) |->
    !serial_bit_clk_oe && !word_select_oe) else $error("not slave after reset");
  pin_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_bit_clk_oe == clkctl_q[CLK_MASTER_BIT]) else $error("pin direction wrong");
  osc_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    oversample_clk_out == osc) else $error("osc pin not driven");
  sample_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid |=> !sample_valid) else $error("sample pulse too long");
  low_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && !frame_q[FRM_ORDER_BIT] |->
    ((sample_out.left & ((16'h0001 << cfg.start_stop_index) - 16'h0001)) == WORD_ZERO))
    else $error("low bits not cleared");
  reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done_now && cfg.sample_accept_mode[1] && !valid_ok_q |=> !sample_valid)
    else $error("invalid sample accepted");
  start_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
    samp_edge && frame_start |=> pos_cnt_q == 9'h1FF) else $error("frame start pos");
  legacy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !freq_q[31] |-> u_synth.mul == MUL_LEGACY) else $error("legacy mode not used");
endmodule
`default_nettype wire

/* File: inc/audio_in_pkg.sv */
// Shared constants, register map and carrier types for the audio capture block.
package audio_in_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFF_FREQ = 8'h00;
  localparam logic [7:0] OFF_CLKCTL = 8'h04;
  localparam logic [7:0] OFF_FRAME = 8'h08;
  localparam logic [7:0] OFF_POS = 8'h0C;
  localparam logic [7:0] OFF_SAMPLE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // Clock control register fields.
  localparam int CLK_MASTER_BIT = 0;
  localparam int CLK_EDGE_BIT = 1;
  localparam int CLK_BITCLK_DIVIDE_LSB = 8;
  localparam int CLK_FRAME_LEN_DIVIDE_LSB = 16;
  // Frame control register fields.
  localparam int FRM_POL_BIT = 0;
  localparam int FRM_ORDER_BIT = 1;
  localparam int FRM_MONO_BIT = 2;
  localparam int FRM_MODE_LSB = 4;
  localparam int FRM_START_STOP_INDEX_LSB = 8;
  localparam int FRM_VALID_LSB = 16;
  // Position register fields.
  localparam int POS_LEFT_LSB = 0;
  localparam int POS_RIGHT_LSB = 16;
  // Reset values.
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [31:0] CLKCTL_RST = 32'h0000_0000;
  localparam logic [31:0] FRAME_RST = 32'h0000_0000;
  localparam logic [31:0] POS_RST = 32'h0000_0000;
  // Synthesizer multipliers and accept modes.
  localparam logic [3:0] MUL_IMPROVED = 4'h9;
  localparam logic [3:0] MUL_LEGACY = 4'h3;
  localparam logic [1:0] MODE_EVERY = 2'h0;
  localparam logic [1:0] MODE_VALID0 = 2'h2;
  localparam logic [1:0] MODE_VALID1 = 2'h3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] MSB_IDX = 4'hF;
  // Receiver configuration carried as one bundle.
  typedef struct packed {
    logic master;
    logic edge_sel;
    logic polarity;
    logic bit_order;
    logic mono;
    logic [1:0] sample_accept_mode;
    logic [3:0] start_stop_index;
    logic [8:0] valid_bit_pos;
    logic [8:0] left_first_pos;
    logic [8:0] right_first_pos;
    logic [8:0] frame_len_divide;
  } rx_cfg_t;
  // Completed sample handed downstream.
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } sample_t;
endpackage

/* File: hdl/osclk_synth.sv */
// Square-wave phase accumulator synthesizer for the oversampling clock.
`timescale 1ns/1ps
`default_nettype none
module osclk_synth
  import audio_in_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] freq_word,
  output logic osc_q
);
  logic [35:0] acc_q;
  logic [35:0] step;
  logic [3:0] mul;

  // Bit 31 picks improved mode, otherwise legacy; the step scales by 9 or 3.
  always_comb begin
    mul = freq_word[31] ? MUL_IMPROVED : MUL_LEGACY;
    step = {4'h0, 1'b0, freq_word[30:0]} * {32'h0000_0000, mul};
  end

  // Accumulator MSB of the 32-bit phase is the output; the multiple wraps.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 36'h0_0000_0000;
      osc_q <= 1'b0;
    end else begin
      acc_q <= {4'h0, acc_q[31:0] + step[31:0]};
      osc_q <= acc_q[31];
    end
  end
endmodule
`default_nettype wire

/* File: hdl/serial_master_gen.sv */
// Bit clock and word select generator used when this end is timing master.
`timescale 1ns/1ps
`default_nettype none
module serial_master_gen
  import audio_in_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc,
  input wire logic [7:0] bitclk_divide,
  input wire logic [8:0] frame_len_divide,
  input wire logic polarity,
  input wire logic edge_sel,
  output logic sck_q,
  output logic ws_q
);
  logic osc_d1_q;
  logic [8:0] half_q;
  logic [8:0] bit_q;
  logic sck_prev_q;
  logic osc_rise;
  logic [8:0] period;
  logic drive_edge;

  assign osc_rise = osc & ~osc_d1_q;
  assign period = {1'b0, bitclk_divide} + 9'h001;
  // Word select changes on the edge opposite to sampling.
  assign drive_edge = edge_sel ? (sck_q & ~sck_prev_q) : (~sck_q & sck_prev_q);

  // Count oversampling edges; toggle phase split so period is divide+1.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_d1_q <= 1'b0;
      half_q <= 9'h000;
      sck_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      osc_d1_q <= osc;
      sck_prev_q <= sck_q;
      // A divide field of zero means divide by one, so the clock follows the oscillator.
      if (bitclk_divide == 8'h00) begin
        sck_q <= osc;
      end else if (osc_rise) begin
        if (half_q >= period - 9'h001) begin
          half_q <= 9'h000;
          sck_q <= 1'b1;
        end else begin
          half_q <= half_q + 9'h001;
          if (half_q + 9'h001 >= {1'b0, period[8:1]}) begin
            sck_q <= 1'b0;
          end
        end
      end
    end
  end

  // Frame of divide+1 bits; the start transition begins each frame.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_q <= 9'h000;
      ws_q <= 1'b1;
    end else if (drive_edge) begin
      if (bit_q >= frame_len_divide) begin
        bit_q <= 9'h000;
        ws_q <= polarity;
      end else begin
        bit_q <= bit_q + 9'h001;
        ws_q <= (bit_q == 9'h000) ? ~polarity : ws_q;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/adc_model.sv */
// Behavioural stereo converter that masters the serial bit clock and word select.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  output logic sck,
  output logic ws,
  output logic sd
);
  // Half bit period, kept off the processor clock grid so the phases drift.
  localparam time HALF = 430ns;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels until the first frame is sent.
  initial begin
    sck = 1'b0;
    ws = 1'b1;
    sd = 1'b0;
  end
  // One frame: a settle bit, a one-bit sync pulse, then the data bits.
  // The settle bit guarantees a start transition even after a polarity change.
  // Lines change on the non-sampling edge; the clock stands still between frames.
  task automatic send(input logic [63:0] b, input int len, input logic pol, input logic edg);
    sck = edg;
    for (int k = -2; k < len; k++) begin
      ws = (k == -1) ? pol : ~pol;
      sd = (k < 0) ? ~sd : b[k];
      #HALF;
      sck = ~edg;
      #HALF;
      sck = edg;
    end
    sd = ~sd; // A released data line must not keep showing the last bit.
  endtask
endmodule
`default_nettype wire

/* File: sim/audio_serial_input_capture_test.sv */
// Self-checking bench for the audio capture block driven by a converter model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module audio_serial_input_capture_test
  import audio_in_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic osc, sck_out, sck_oe, ws_out, ws_oe, m_sck, m_ws, m_sd, sck_w, ws_w, svalid;
  sample_t smp_w, smp;
  sample_t q[$];
  int errors, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  // Pin resolution: whoever has its enable up owns the wire.
  assign sck_w = sck_oe ? sck_out : m_sck;
  assign ws_w = ws_oe ? ws_out : m_ws;
  audio_in_capture dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .oversample_clk_out(osc),
    .serial_bit_clk_in(sck_w), .serial_bit_clk_out(sck_out), .serial_bit_clk_oe(sck_oe),
    .word_select_in(ws_w), .word_select_out(ws_out), .word_select_oe(ws_oe),
    .serial_data_in(m_sd), .sample_valid(svalid), .sample_out(smp_w)
  );
  adc_model adc (.sck(m_sck), .ws(m_ws), .sd(m_sd));
  // Processor clock, 100 ns period.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Collect every completed sample handed downstream.
  always @(posedge hclk) begin
    if (svalid === 1'b1) q.push_back(smp_w);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Expected parallel word; unfilled positions stay zero.
  function automatic logic [15:0] exp_word(logic [63:0] b, int p, logic lsb, int ss);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = ss; i < 16; i++) begin
      w[i] = lsb ? b[p + i - ss] : b[p + 15 - i];
    end
    return w;
  endfunction
  // Rising edges the synthesizer should give in a window of cyc clocks.
  function automatic int exp_osc(logic [31:0] w, int cyc);
    return int'((longint'(w[30:0]) * (w[31] ? 9 : 3) * cyc) >> 32);
  endfunction
  // Edge counts are sampled, so the phase at both ends costs up to two edges.
  function automatic bit near(int a, int b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction
  // One single word transfer; must be entered just after a rising edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Counts osc and bit clock rises and word select falls over cyc clocks.
  task automatic count(input int cyc, output int no, output int ns, output int nf);
    logic po, ps, pw;
    no = 0;
    ns = 0;
    nf = 0;
    po = osc;
    ps = sck_out;
    pw = ws_out;
    repeat (cyc) begin
      @(posedge hclk);
      no += int'(osc & ~po);
      ns += int'(sck_out & ~ps);
      nf += int'(pw & ~ws_out);
      po = osc;
      ps = sck_out;
      pw = ws_out;
    end
  endtask
  // Sends one 48-bit frame and checks acceptance, the left word and, unless mono, the right word.
  task automatic run_frame(input logic wr, input logic [63:0] b, input logic [31:0] fr,
                           input logic edg, input logic [8:0] lp, input logic [8:0] rp);
    logic acc;
    logic [15:0] el, er;
    if (wr) begin
      ahb(1'b1, OFF_CLKCTL, {30'h0, edg, 1'b0});
      ahb(1'b1, OFF_FRAME, fr);
      ahb(1'b1, OFF_POS, {7'h00, rp, 7'h00, lp});
    end
    q.delete();
    adc.send(b, 48, fr[0], edg);
    repeat (40) @(posedge hclk);
    el = exp_word(b, lp, fr[1], fr[11:8]);
    er = exp_word(b, rp, fr[1], fr[11:8]);
    acc = (fr[5:4] == 2'h0) || (fr[5] && b[fr[24:16]] == fr[4]);
    `CHK(q.size(), int'(acc))
    if (q.size() > 0) begin
      smp = q.pop_front();
      `CHK(smp.left, el)
      if (!fr[2]) begin
        `CHK(smp.right, er)
        ahb(1'b0, OFF_SAMPLE, 32'h0);
        `CHK(rd, {el, er})
      end
    end
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The whole plan takes about 3 ms; a hang is cut off well beyond that.
  initial begin
    #8ms;
    errors++;
    end_of_test();
  end
  // Main sequence: reset, registers, synthesizer, master timing, then frames.
  initial begin
    int no, ns, nf;
    logic [31:0] w, fr;
    errors = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    void'($urandom(37));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, (i == 4) ? 8'h40 : 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0)
    end
    `CHK({sck_oe, ws_oe}, 2'h0)
    run_frame(1'b0, {$urandom, $urandom}, 32'h0, 1'b0, 9'h0, 9'h0);
    for (int i = 0; i < 5; i++) begin
      w = (i == 0) ? 32'h0 : (i == 1) ? 32'h02AA_AAAB : (i == 2) ? 32'h80E3_8E39 :
          (i == 3) ? 32'($urandom % 500000000) : (32'h8000_0000 | ($urandom % 160000000));
      ahb(1'b1, OFF_FREQ, w);
      repeat (8) @(posedge hclk);
      count(3200, no, ns, nf);
      `CHK(near(no, exp_osc(w, 3200)), 1'b1)
    end
    ahb(1'b1, OFF_FREQ, 32'h1555_5555);
    for (int d = 0; d < 3; d += 2) begin
      ahb(1'b1, OFF_CLKCTL, {7'h00, 9'(3 + d), 8'(d), 8'h01});
      repeat (40) @(posedge hclk);
      count(3200, no, ns, nf);
      `CHK({sck_oe, ws_oe}, 2'h3)
      `CHK(near(no, 800), 1'b1)
      `CHK(near(ns, no / (d + 1)), 1'b1)
      `CHK(near(nf, ns / (4 + d)), 1'b1)
    end
    ahb(1'b1, OFF_CLKCTL, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK({sck_oe, ws_oe}, 2'h0)
    for (int i = 0; i < 16; i++) begin
      fr = {7'h00, 9'($urandom % 48), 4'h0, 4'((i < 2) ? i * 15 : $urandom), 2'h0,
            2'($urandom), 1'b0, 3'($urandom)};
      run_frame(1'b1, {$urandom, $urandom}, fr, 1'($urandom), 9'($urandom % 17),
                9'(16 + $urandom % 17));
    end
    // Pulses never come back to back here, so the sticky overrun stays clear.
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK({hresp, rd}, 33'h0)
    end_of_test();
  end
endmodule
`default_nettype wire
